// File: tc_pin_model.sv
// far-side model: external event source on the capture inputs
`timescale 1ns/1ps
module tc_pin_model (
  input wire logic clk,
  input wire logic [1:0] sel,
  input wire logic lvl,
  output logic capture_pin_a,
  output logic capture_pin_b,
  output logic comparator_output
);
  // =====================================================
  // levels change off the sampling edge, like a port output
  initial begin
    capture_pin_a = 1'b0;
    capture_pin_b = 1'b0;
    comparator_output = 1'b0;
  end
  always @(negedge clk) begin
    if (sel == 2'h0) capture_pin_a <= lvl;
    if (sel == 2'h1) capture_pin_b <= lvl;
    if (sel == 2'h2) comparator_output <= lvl;
  end
endmodule

// File: tc_pkg.sv
// constants, register map and state types for the 16-bit timer with capture
package tc_pkg;

  // =====================================================
  // register locations on the byte-wide i/o port
  localparam logic [3:0] TC_ADR_CTRL_A = 4'h0;
  localparam logic [3:0] TC_ADR_CTRL_B = 4'h1;
  localparam logic [3:0] TC_ADR_CTRL_C = 4'h2;
  localparam logic [3:0] TC_ADR_CNT_LO = 4'h4;
  localparam logic [3:0] TC_ADR_CNT_HI = 4'h5;
  localparam logic [3:0] TC_ADR_CAP_LO = 4'h6;
  localparam logic [3:0] TC_ADR_CAP_HI = 4'h7;
  localparam logic [3:0] TC_ADR_FLAGS = 4'h8;
  localparam logic [3:0] TC_ADR_MASK = 4'h9;

  // =====================================================
  // field positions
  localparam int TC_CTA_WGM_LSB = 0;
  localparam int TC_CTB_CS_LSB = 0;
  localparam int TC_CTB_WGM_LSB = 3;
  localparam int TC_CTB_EDGE_BIT = 6;
  localparam int TC_CTB_FILT_BIT = 7;
  localparam int TC_CTC_SRC_LSB = 0;
  localparam int TC_CTC_RTG_BIT = 2;
  localparam int TC_FLG_WRAP_BIT = 0;
  localparam int TC_FLG_CAP_BIT = 5;

  // =====================================================
  // modes and fixed values
  localparam logic [2:0] TC_CS_STOP = 3'h0;
  localparam logic [2:0] TC_CS_SYSCLK = 3'h1;
  localparam logic [1:0] TC_SRC_PIN_A = 2'h0;
  localparam logic [1:0] TC_SRC_PIN_B = 2'h1;
  localparam logic [1:0] TC_SRC_COMP = 2'h2;
  localparam logic [3:0] TC_WGM_PC_CAP = 4'h8;
  localparam logic [3:0] TC_WGM_PFC_CAP = 4'ha;
  localparam logic [3:0] TC_WGM_CTC_CAP = 4'hc;
  localparam logic [3:0] TC_WGM_FAST_CAP = 4'he;
  localparam logic [15:0] TC_FIXED_TOP = 16'hffff;
  localparam logic [15:0] TC_BOTTOM = 16'h0000;
  localparam int TC_FILT_SAMPLES = 4;

  // =====================================================
  // carriers and state
  typedef struct packed {
    logic rd;
    logic wr;
    logic [3:0] addr;
    logic [7:0] wdata;
  } tc_io_req_t;

  typedef struct packed {
    logic [7:0] ctrl_a;
    logic [7:0] ctrl_b;
    logic [7:0] ctrl_c;
    logic [7:0] mask;
    logic [7:0] temp;
    logic [15:0] cnt;
    logic [15:0] icr;
    logic dir_down;
    logic wrap_f;
    logic cap_f;
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] s3;
    logic [2:0] stab;
    logic [TC_FILT_SAMPLES-1:0] smp;
    logic filt;
    logic prev;
    logic [7:0] rdata;
    logic cap_irq;
    logic wrap_irq;
    logic at_top;
    logic at_bot;
  } tc_state_t;

  localparam tc_state_t TC_STATE_RST = '0;

endpackage

// File: tc_timer16_capture.sv
// 16-bit bidirectional timer/counter with input capture unit
`timescale 1ns/1ps
// Overview of operation
// - counter seen as two bytes, high via temp
// - low read/write moves high byte through temp
// - clock select zero stops counter, access stays
// - cpu write beats clear and count
// - tick clears, increments or decrements; top, bottom
// - four-bit mode split across two controls
// - wrap flag set per mode, raises interrupt
// - capture pin retrigger acts like top
// - qualified edge copies counter into capture register
// - capture flag set with the capture copy
// - flag interrupt, cleared by ack or one
// - capture low read fills temp for high
// - capture register writable only in capture-top modes
// - pins a and b are trigger sources
// - source change may capture; software clears flag
// - filter output changes after four equal samples
// - filter enable bit, system clock, four cycles
// - capture inputs idle in capture-top modes
// - pin driven by port still captures
// - new capture overwrites unread value
// - retrigger ors capture into top
module tc_timer16_capture (
  input wire logic clk,
  input wire logic sys_rst,
  input wire tc_pkg::tc_io_req_t io_req,
  input wire logic prescale_tick,
  input wire logic capture_pin_a,
  input wire logic capture_pin_b,
  input wire logic comparator_output,
  input wire logic capture_irq_ack,
  input wire logic wrap_irq_ack,
  output logic [7:0] io_rdata,
  output logic capture_irq,
  output logic wrap_irq,
  output logic top_ind,
  output logic bottom_ind
);

  tc_pkg::tc_state_t q;
  tc_pkg::tc_state_t d;

  // =====================================================
  // decoded controls
  logic [3:0] waveform_mode_field;
  logic [2:0] tick_source_select;
  logic [1:0] src_sel;
  logic filter_enable;
  logic edge_rising;
  logic retrig_en;
  logic cap_top_mode;
  logic dual_slope;
  logic timer_tick;
  logic [15:0] top_val;
  logic sel_in;
  logic cap_ev;
  logic retrigger_request;
  logic top_hit;
  logic wr_cnt_lo;
  logic wr_cap_lo;
  logic rd_cnt_lo;
  logic rd_cap_lo;

  assign waveform_mode_field = {q.ctrl_b[tc_pkg::TC_CTB_WGM_LSB+:2],
                                q.ctrl_a[tc_pkg::TC_CTA_WGM_LSB+:2]};
  assign tick_source_select = q.ctrl_b[tc_pkg::TC_CTB_CS_LSB+:3];
  assign src_sel = q.ctrl_c[tc_pkg::TC_CTC_SRC_LSB+:2];
  assign filter_enable = q.ctrl_b[tc_pkg::TC_CTB_FILT_BIT];
  assign edge_rising = q.ctrl_b[tc_pkg::TC_CTB_EDGE_BIT];
  assign retrig_en = q.ctrl_c[tc_pkg::TC_CTC_RTG_BIT];

  assign cap_top_mode = (waveform_mode_field == tc_pkg::TC_WGM_PC_CAP) ||
                        (waveform_mode_field == tc_pkg::TC_WGM_PFC_CAP) ||
                        (waveform_mode_field == tc_pkg::TC_WGM_CTC_CAP) ||
                        (waveform_mode_field == tc_pkg::TC_WGM_FAST_CAP);
  assign dual_slope = (waveform_mode_field == tc_pkg::TC_WGM_PC_CAP) ||
                      (waveform_mode_field == tc_pkg::TC_WGM_PFC_CAP);
  assign top_val = cap_top_mode ? q.icr : tc_pkg::TC_FIXED_TOP;

  // stopped when select is zero, else system clock or prescaled tick
  assign timer_tick = (tick_source_select == tc_pkg::TC_CS_SYSCLK) ||
                      ((tick_source_select != tc_pkg::TC_CS_STOP) &&
                       prescale_tick);

  // source mux on synchronised levels
  assign sel_in = (src_sel == tc_pkg::TC_SRC_PIN_B) ? q.stab[1] :
                  (src_sel == tc_pkg::TC_SRC_COMP) ? q.stab[2] :
                  q.stab[0];

  assign cap_ev = (q.filt != q.prev) && (q.filt == edge_rising) &&
                  !cap_top_mode;
  assign retrigger_request = retrig_en && cap_ev &&
                             (src_sel != tc_pkg::TC_SRC_COMP);
  assign top_hit = (q.cnt == top_val) || retrigger_request;

  assign wr_cnt_lo = io_req.wr && (io_req.addr == tc_pkg::TC_ADR_CNT_LO);
  assign wr_cap_lo = io_req.wr && (io_req.addr == tc_pkg::TC_ADR_CAP_LO);
  assign rd_cnt_lo = io_req.rd && (io_req.addr == tc_pkg::TC_ADR_CNT_LO);
  assign rd_cap_lo = io_req.rd && (io_req.addr == tc_pkg::TC_ADR_CAP_LO);

  // =====================================================
  // next state
  always_comb begin
    d = q;
    // three-stage sync, level accepted when stages two and three agree
    d.s1 = {comparator_output, capture_pin_b, capture_pin_a};
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.stab = (q.s2 & q.s3) | (q.stab & (q.s2 | q.s3));
    // filter and edge detector, frozen in capture-top modes
    d.prev = q.filt;
    if (!cap_top_mode) begin
      d.smp = {q.smp[tc_pkg::TC_FILT_SAMPLES-2:0], sel_in};
      if (!filter_enable) begin
        d.filt = sel_in;
      end else if (&q.smp) begin
        d.filt = 1'b1;
      end else if (~|q.smp) begin
        d.filt = 1'b0;
      end
    end

    // control registers
    if (io_req.wr) begin
      if (io_req.addr == tc_pkg::TC_ADR_CTRL_A) begin
        d.ctrl_a = io_req.wdata;
      end else if (io_req.addr == tc_pkg::TC_ADR_CTRL_B) begin
        d.ctrl_b = io_req.wdata;
      end else if (io_req.addr == tc_pkg::TC_ADR_CTRL_C) begin
        d.ctrl_c = io_req.wdata;
      end else if (io_req.addr == tc_pkg::TC_ADR_MASK) begin
        d.mask = io_req.wdata;
      end else if (io_req.addr == tc_pkg::TC_ADR_CNT_HI ||
                   io_req.addr == tc_pkg::TC_ADR_CAP_HI) begin
        d.temp = io_req.wdata;
      end
    end
    if (rd_cnt_lo) begin
      d.temp = q.cnt[15:8];
    end else if (rd_cap_lo) begin
      d.temp = q.icr[15:8];
    end

    // counter: cpu write first, then the tick
    if (wr_cnt_lo) begin
      d.cnt = {q.temp, io_req.wdata};
    end else if (timer_tick) begin
      if (!dual_slope) begin
        d.cnt = top_hit ? tc_pkg::TC_BOTTOM : q.cnt + 16'h0001;
      end else if (!q.dir_down) begin
        if (top_hit) begin
          d.dir_down = 1'b1;
          d.cnt = q.cnt - 16'h0001;
        end else begin
          d.cnt = q.cnt + 16'h0001;
        end
      end else if (q.cnt == tc_pkg::TC_BOTTOM) begin
        d.dir_down = 1'b0;
        d.cnt = q.cnt + 16'h0001;
      end else begin
        d.cnt = q.cnt - 16'h0001;
      end
    end

    // capture register: event overwrites, cpu write in capture-top only
    if (cap_ev) begin
      d.icr = q.cnt;
    end else if (wr_cap_lo && cap_top_mode) begin
      d.icr = {q.temp, io_req.wdata};
    end

    // flags: set wins over clear
    d.cap_f = q.cap_f && !capture_irq_ack &&
              !(io_req.wr && io_req.addr == tc_pkg::TC_ADR_FLAGS &&
                io_req.wdata[tc_pkg::TC_FLG_CAP_BIT]);
    if (cap_ev) begin
      d.cap_f = 1'b1;
    end
    d.wrap_f = q.wrap_f && !wrap_irq_ack &&
               !(io_req.wr && io_req.addr == tc_pkg::TC_ADR_FLAGS &&
                 io_req.wdata[tc_pkg::TC_FLG_WRAP_BIT]);
    if (!wr_cnt_lo && timer_tick) begin
      if (!dual_slope && top_hit) begin
        d.wrap_f = 1'b1;
      end else if (dual_slope && q.dir_down &&
                   q.cnt == tc_pkg::TC_BOTTOM) begin
        d.wrap_f = 1'b1;
      end
    end

    d.cap_irq = d.cap_f && q.mask[tc_pkg::TC_FLG_CAP_BIT];
    d.wrap_irq = d.wrap_f && q.mask[tc_pkg::TC_FLG_WRAP_BIT];
    d.at_top = (d.cnt == top_val);
    d.at_bot = (d.cnt == tc_pkg::TC_BOTTOM);

    // registered read data
    if (io_req.rd) begin
      if (io_req.addr == tc_pkg::TC_ADR_CTRL_A) begin
        d.rdata = q.ctrl_a;
      end else if (io_req.addr == tc_pkg::TC_ADR_CTRL_B) begin
        d.rdata = q.ctrl_b;
      end else if (io_req.addr == tc_pkg::TC_ADR_CTRL_C) begin
        d.rdata = q.ctrl_c;
      end else if (io_req.addr == tc_pkg::TC_ADR_CNT_LO) begin
        d.rdata = q.cnt[7:0];
      end else if (io_req.addr == tc_pkg::TC_ADR_CAP_LO) begin
        d.rdata = q.icr[7:0];
      end else if (io_req.addr == tc_pkg::TC_ADR_CNT_HI ||
                   io_req.addr == tc_pkg::TC_ADR_CAP_HI) begin
        d.rdata = q.temp;
      end else if (io_req.addr == tc_pkg::TC_ADR_FLAGS) begin
        d.rdata = 8'h00;
        d.rdata[tc_pkg::TC_FLG_CAP_BIT] = q.cap_f;
        d.rdata[tc_pkg::TC_FLG_WRAP_BIT] = q.wrap_f;
      end else if (io_req.addr == tc_pkg::TC_ADR_MASK) begin
        d.rdata = q.mask;
      end else begin
        d.rdata = 8'h00;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q <= tc_pkg::TC_STATE_RST;
    end else begin
      q <= d;
    end
  end

  assign io_rdata = q.rdata;
  assign capture_irq = q.cap_irq;
  assign wrap_irq = q.wrap_irq;
  assign top_ind = q.at_top;
  assign bottom_ind = q.at_bot;

  // =====================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_cnt_load;
    wr_cnt_lo |=> q.cnt == {$past(q.temp), $past(io_req.wdata)};
  endproperty
  a_cnt_load: assert property (p_cnt_load)
    else $error("counter low write did not load temp and data");

  property p_temp_snap;
    rd_cnt_lo |=> q.temp == $past(q.cnt[15:8]);
  endproperty
  a_temp_snap: assert property (p_temp_snap)
    else $error("counter low read did not copy high byte");

  property p_stopped;
    (tick_source_select == tc_pkg::TC_CS_STOP) && !wr_cnt_lo
      |=> $stable(q.cnt);
  endproperty
  a_stopped: assert property (p_stopped)
    else $error("counter moved with no clock selected");

  property p_capture;
    cap_ev |=> q.icr == $past(q.cnt) && q.cap_f;
  endproperty
  a_capture: assert property (p_capture)
    else $error("capture copy and flag not together");

  property p_irq;
    q.cap_irq == (q.cap_f && $past(q.mask[tc_pkg::TC_FLG_CAP_BIT]));
  endproperty
  a_irq: assert property (p_irq)
    else $error("capture interrupt does not follow flag and enable");

  sequence s_cap_lo;
    rd_cap_lo;
  endsequence
  sequence s_cap_hi;
    io_req.rd && io_req.addr == tc_pkg::TC_ADR_CAP_HI;
  endsequence
  sequence s_gap;
    !io_req.rd && !io_req.wr;
  endsequence
  property p_cap_pair;
    s_cap_lo ##1 s_gap ##1 s_cap_hi |=> io_rdata == $past(q.icr[15:8], 3);
  endproperty
  a_cap_pair: assert property (p_cap_pair)
    else $error("capture high read did not return snapshot");

  property p_cap_wr_guard;
    wr_cap_lo && !cap_top_mode && !cap_ev |=> $stable(q.icr);
  endproperty
  a_cap_wr_guard: assert property (p_cap_wr_guard)
    else $error("capture register written outside capture-top mode");

  property p_filter;
    filter_enable && !cap_top_mode && $past(filter_enable) &&
      (q.filt != $past(q.filt))
      |-> ($past(q.smp) == '1) || ($past(q.smp) == '0);
  endproperty
  a_filter: assert property (p_filter)
    else $error("filter changed without four equal samples");

  property p_retrigger;
    retrigger_request && timer_tick && !dual_slope && !wr_cnt_lo
      |=> q.cnt == tc_pkg::TC_BOTTOM;
  endproperty
  a_retrigger: assert property (p_retrigger)
    else $error("retrigger did not act as top");

  property p_wrap;
    timer_tick && !dual_slope && !wr_cnt_lo && (q.cnt == top_val)
      |=> q.wrap_f;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("wrap flag not set at top");

  property p_idle_cap;
    cap_top_mode |-> !cap_ev ##1
      ($stable(q.filt) && $stable(q.smp));
  endproperty
  a_idle_cap: assert property (p_idle_cap)
    else $error("capture in capture-top mode");

  property p_wrap_irq;
    q.wrap_irq == (q.wrap_f && $past(q.mask[tc_pkg::TC_FLG_WRAP_BIT]));
  endproperty
  a_wrap_irq: assert property (p_wrap_irq)
    else $error("wrap interrupt does not follow flag and enable");

  property p_flag_clear;
    (capture_irq_ack ||
     (io_req.wr && io_req.addr == tc_pkg::TC_ADR_FLAGS &&
      io_req.wdata[tc_pkg::TC_FLG_CAP_BIT])) && !cap_ev |=> !q.cap_f;
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("capture flag not cleared by ack or write one");

  property p_temp_load;
    io_req.wr && io_req.addr == tc_pkg::TC_ADR_CNT_HI
      |=> q.temp == $past(io_req.wdata);
  endproperty
  a_temp_load: assert property (p_temp_load)
    else $error("counter high write did not reach temp");

endmodule

// File: test_timer16_counter_input_capture.sv
// self-checking bench for the 16-bit timer with capture
`timescale 1ns/1ps
module test_timer16_counter_input_capture;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  tc_pkg::tc_io_req_t io_req = '0;
  logic prescale_tick = 1'b0;
  logic capture_irq_ack = 1'b0;
  logic wrap_irq_ack = 1'b0;
  logic [1:0] pin_sel = 2'h0;
  logic pin_lvl = 1'b0;
  logic pa, pb, pc;
  logic [7:0] io_rdata;
  logic capture_irq, wrap_irq, top_ind, bottom_ind;
  int errors = 0;
  int comparisons = 0;
  int m_cnt = 0, m_icr = 0, m_temp = 0, m_flags = 0, m_ca = 0, m_cb = 0;

  always #5 clk = ~clk;

  tc_pin_model pins (.clk(clk), .sel(pin_sel), .lvl(pin_lvl),
    .capture_pin_a(pa), .capture_pin_b(pb), .comparator_output(pc));

  tc_timer16_capture dut (.clk(clk), .sys_rst(sys_rst), .io_req(io_req),
    .prescale_tick(prescale_tick), .capture_pin_a(pa), .capture_pin_b(pb),
    .comparator_output(pc), .capture_irq_ack(capture_irq_ack),
    .wrap_irq_ack(wrap_irq_ack), .io_rdata(io_rdata),
    .capture_irq(capture_irq), .wrap_irq(wrap_irq), .top_ind(top_ind),
    .bottom_ind(bottom_ind));

  // =====================================================
  // shared tasks
  task automatic tally_and_finish();
    if (errors == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] exp,
                       input logic [7:0] seen);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  function automatic bit cap_mode();
    int m;
    m = {m_cb[4:3], m_ca[1:0]};
    return m == 8 || m == 10 || m == 12 || m == 14;
  endfunction

  task automatic wr(input logic [3:0] a, input logic [7:0] d,
                    input logic tk = 1'b0);
    io_req.wr = 1'b1;
    io_req.addr = a;
    io_req.wdata = d;
    prescale_tick = tk;
    @(negedge clk);
    io_req.wr = 1'b0;
    prescale_tick = 1'b0;
    case (a)
      tc_pkg::TC_ADR_CTRL_A: m_ca = d;
      tc_pkg::TC_ADR_CTRL_B: m_cb = d;
      tc_pkg::TC_ADR_CNT_HI, tc_pkg::TC_ADR_CAP_HI: m_temp = d;
      tc_pkg::TC_ADR_CNT_LO: m_cnt = {m_temp[7:0], d};
      tc_pkg::TC_ADR_CAP_LO: if (cap_mode()) m_icr = {m_temp[7:0], d};
      tc_pkg::TC_ADR_FLAGS: m_flags = m_flags & ~int'(d);
      default: ;
    endcase
    @(negedge clk);
  endtask

  task automatic rd(input logic [3:0] a, input string what);
    logic [7:0] e;
    case (a)
      tc_pkg::TC_ADR_CNT_LO: begin
        e = m_cnt[7:0];
        m_temp = m_cnt[15:8];
      end
      tc_pkg::TC_ADR_CAP_LO: begin
        e = m_icr[7:0];
        m_temp = m_icr[15:8];
      end
      tc_pkg::TC_ADR_CNT_HI, tc_pkg::TC_ADR_CAP_HI: e = m_temp[7:0];
      tc_pkg::TC_ADR_FLAGS: e = m_flags[7:0];
      default: e = 8'h00;
    endcase
    io_req.rd = 1'b1;
    io_req.addr = a;
    @(negedge clk);
    io_req.rd = 1'b0;
    @(negedge clk);
    check(what, e, io_rdata);
  endtask

  task automatic tick(input int n);
    repeat (n) begin
      prescale_tick = 1'b1;
      @(negedge clk);
      prescale_tick = 1'b0;
      @(negedge clk);
      if (m_cnt == 16'hffff) begin
        m_cnt = 0;
        m_flags = m_flags | 1;
      end else m_cnt++;
    end
  endtask

  task automatic pulse_ack(input bit cap);
    if (cap) capture_irq_ack = 1'b1;
    else wrap_irq_ack = 1'b1;
    @(negedge clk);
    capture_irq_ack = 1'b0;
    wrap_irq_ack = 1'b0;
    m_flags = m_flags & (cap ? ~32'h20 : ~32'h1);
    @(negedge clk);
  endtask

  task automatic event_on(input logic [1:0] s, input logic l, input bit exp);
    int i;
    pin_sel = s;
    pin_lvl = l;
    i = 0;
    if (exp) begin
      while (capture_irq !== 1'b1 && i < 40) begin
        @(negedge clk);
        i++;
      end
      if (i == 40) begin
        check("capture_wait", 8'h01, {7'h0, capture_irq});
        tally_and_finish();
      end
      m_icr = m_cnt;
      m_flags = m_flags | 32'h20;
    end else cyc(20);
  endtask

  task automatic set_cnt(input logic [15:0] v, input logic tk = 1'b0);
    wr(tc_pkg::TC_ADR_CNT_HI, v[15:8]);
    wr(tc_pkg::TC_ADR_CNT_LO, v[7:0], tk);
  endtask

  // =====================================================
  // main sequence
  initial begin
    void'($urandom(32'h8b9b));
    repeat (4) @(negedge clk);
    sys_rst = 1'b0;
    cyc(2);
    check("bottom", 8'h01, {7'h0, bottom_ind});
    wr(tc_pkg::TC_ADR_MASK, 8'h21);
    set_cnt(16'($urandom));
    cyc(5);
    rd(tc_pkg::TC_ADR_CNT_LO, "cnt_lo");
    rd(tc_pkg::TC_ADR_CNT_HI, "cnt_hi");
    wr(tc_pkg::TC_ADR_CTRL_B, 8'h02);
    set_cnt(16'hfffe);
    tick(1);
    check("top", 8'h01, {7'h0, top_ind});
    tick(1);
    rd(tc_pkg::TC_ADR_FLAGS, "wrap_flag");
    check("wrap_irq", 8'h01, {7'h0, wrap_irq});
    pulse_ack(1'b0);
    rd(tc_pkg::TC_ADR_FLAGS, "wrap_ack");
    tick(1 + $urandom % 8);
    rd(tc_pkg::TC_ADR_CNT_LO, "count_lo");
    rd(tc_pkg::TC_ADR_CNT_HI, "count_hi");
    set_cnt(16'h1234, 1'b1);
    rd(tc_pkg::TC_ADR_CNT_LO, "prio_lo");
    rd(tc_pkg::TC_ADR_CNT_HI, "prio_hi");
    for (int s = 0; s < 3; s++) begin
      wr(tc_pkg::TC_ADR_CTRL_C, 8'(s));
      for (int l = 1; l >= 0; l--) begin
        set_cnt(16'($urandom));
        wr(tc_pkg::TC_ADR_CTRL_B, l ? 8'h40 : 8'h00);
        wr(tc_pkg::TC_ADR_FLAGS, 8'h20);
        event_on(2'(s), 1'(l), 1'b1);
      end
      check("cap_irq", 8'h01, {7'h0, capture_irq});
      rd(tc_pkg::TC_ADR_CAP_LO, "cap_lo");
      rd(tc_pkg::TC_ADR_CAP_HI, "cap_hi");
      rd(tc_pkg::TC_ADR_FLAGS, "cap_flag");
      pulse_ack(1'b1);
      rd(tc_pkg::TC_ADR_FLAGS, "cap_ack");
    end
    wr(tc_pkg::TC_ADR_CTRL_C, 8'h04);
    set_cnt(16'h0100);
    wr(tc_pkg::TC_ADR_CTRL_B, 8'h41);
    event_on(2'h0, 1'b1, 1'b1);
    m_cnt = 0;
    m_flags = m_flags | 32'h1;
    rd(tc_pkg::TC_ADR_CNT_LO, "rtg_lo");
    rd(tc_pkg::TC_ADR_CNT_HI, "rtg_hi");
    rd(tc_pkg::TC_ADR_FLAGS, "rtg_flags");
    wr(tc_pkg::TC_ADR_FLAGS, 8'h21);
    event_on(2'h0, 1'b0, 1'b0);
    wr(tc_pkg::TC_ADR_CTRL_C, 8'h00);
    wr(tc_pkg::TC_ADR_CTRL_B, 8'hc0);
    set_cnt(16'($urandom));
    pin_sel = 2'h0;
    pin_lvl = 1'b1;
    cyc(2);
    pin_lvl = 1'b0;
    cyc(20);
    rd(tc_pkg::TC_ADR_FLAGS, "glitch");
    event_on(2'h0, 1'b1, 1'b1);
    rd(tc_pkg::TC_ADR_CAP_LO, "filt_lo");
    wr(tc_pkg::TC_ADR_CAP_HI, 8'h55);
    wr(tc_pkg::TC_ADR_CAP_LO, 8'haa);
    rd(tc_pkg::TC_ADR_CAP_LO, "cap_ro");
    wr(tc_pkg::TC_ADR_CTRL_B, 8'h18);
    wr(tc_pkg::TC_ADR_FLAGS, 8'h20);
    wr(tc_pkg::TC_ADR_CAP_HI, 8'($urandom));
    wr(tc_pkg::TC_ADR_CAP_LO, 8'($urandom));
    rd(tc_pkg::TC_ADR_CAP_LO, "top_lo");
    rd(tc_pkg::TC_ADR_CAP_HI, "top_hi");
    event_on(2'h0, 1'b0, 1'b0);
    rd(tc_pkg::TC_ADR_FLAGS, "no_cap");
    wr(tc_pkg::TC_ADR_CTRL_B, 8'h12);
    wr(tc_pkg::TC_ADR_CAP_HI, 8'h00);
    wr(tc_pkg::TC_ADR_CAP_LO, 8'h05);
    set_cnt(16'h0004);
    tick(1);
    check("dual_top", 8'h01, {7'h0, top_ind});
    tick(1);
    // dual slope turns at top 5 and steps back down
    m_cnt = 16'h0004;
    rd(tc_pkg::TC_ADR_CNT_LO, "dual_lo");
    rd(tc_pkg::TC_ADR_CNT_HI, "dual_hi");
    rd(4'hf, "unmapped");
    tally_and_finish();
  end
endmodule
